// ### design/charger_pkg.sv
// Package with register map, field layout, reset values and timing for the charger pin control
package charger_pkg;

    localparam int CLK_HZ        = 50_000_000;

    // Alert pulse width and push-button timings, in their own units
    localparam int ALERT_PULSE_US = 256;
    localparam int SHIP_HOLD_MS   = 1000;
    localparam int RESET_HOLD_MS  = 1000;
    localparam int SWITCH_OFF_MS  = 300;

    localparam int ALERT_CYC      = (CLK_HZ / 1_000_000) * ALERT_PULSE_US;
    localparam int SHIP_HOLD_CYC  = (CLK_HZ / 1000) * SHIP_HOLD_MS;
    localparam int RESET_HOLD_CYC = (CLK_HZ / 1000) * RESET_HOLD_MS;
    localparam int SWITCH_OFF_CYC = (CLK_HZ / 1000) * SWITCH_OFF_MS;

    localparam int CNT_W  = 26;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LIM_W  = 6;
    localparam int IRQ_W  = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_INLIM    = 8'h01;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h02;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h03;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR  = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN   = 8'h05;
    localparam logic [ADDR_W-1:0] REG_SHIP     = 8'h06;
    localparam logic [ADDR_W-1:0] REG_EFF_LIM  = 8'h07;

    // Control and ship register fields
    localparam int CTRL_BOOST_BIT  = 0;
    localparam int CTRL_CHARGE_BIT = 1;
    localparam int CTRL_PINLIM_BIT = 2;
    localparam int SHIP_ENTER_BIT  = 0;

    // Status register fields
    localparam int ST_BOOST  = 0;
    localparam int ST_CHARGE = 1;
    localparam int ST_THERM  = 2;
    localparam int ST_SWITCH = 3;
    localparam int ST_SHIP   = 4;
    localparam int ST_SUPPLY = 5;

    // Interrupt status fields
    localparam int EV_CHARGE = 0;
    localparam int EV_BOOST  = 1;
    localparam int EV_THERM  = 2;
    localparam int EV_SWITCH = 3;

    // Reset values
    localparam logic [2:0]       CTRL_RST   = 3'h2;
    localparam logic [LIM_W-1:0] INLIM_RST  = 6'h3F;
    localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

    typedef enum logic [2:0] {
        SW_ON   = 3'b001,
        SW_SHIP = 3'b010,
        SW_OFF  = 3'b100
    } switch_state_e;

endpackage

// ### design/charger_pin_ctrl.sv
// Charger pin control logic: alert pulse, boost and charge gating, input limit, push button
`timescale 1ns/1ps

module charger_pin_ctrl
    import charger_pkg::*;
#(
    parameter int ALERT_CYC_P      = charger_pkg::ALERT_CYC,
    parameter int SHIP_HOLD_CYC_P  = charger_pkg::SHIP_HOLD_CYC,
    parameter int RESET_HOLD_CYC_P = charger_pkg::RESET_HOLD_CYC,
    parameter int SWITCH_OFF_CYC_P = charger_pkg::SWITCH_OFF_CYC
) (
    input  wire logic                            core_clk,            // 50 MHz clock
    input  wire logic                            rst,                 // Sync reset, high
    input  wire logic [charger_pkg::ADDR_W-1:0]  addr,                // Register address
    input  wire logic [charger_pkg::DATA_W-1:0]  wdata,               // Write data
    input  wire logic                            wr,                  // Write strobe
    input  wire logic                            rd,                  // Read strobe
    output logic      [charger_pkg::DATA_W-1:0]  rdata,               // Read data, next cycle
    input  wire logic                            boost_request_pin,   // Boost request, high
    input  wire logic                            charge_enable_n_pin, // Charge enable, low
    input  wire logic                            push_button_input,   // Button, low active
    input  wire logic                            thermistor_sense_ok, // Thermistor in window
    input  wire logic                            input_supply_ok,     // Input supply present
    input  wire logic [charger_pkg::LIM_W-1:0]   input_limit_pin,     // Pin-set limit code
    output logic                                 alert_out,           // Alert pad level
    output logic                                 alert_oe,            // Alert pad drive enable
    output logic                                 boost_enable,        // Boost mode active
    output logic                                 charge_enable,       // Charging active
    output logic                                 battery_switch_on,   // Battery switch closed
    output logic      [charger_pkg::LIM_W-1:0]   input_limit_eff,     // Effective input limit
    output logic                                 irq                  // Level interrupt
);
    import charger_pkg::*;

    localparam logic [CNT_W-1:0] ALERT_LIM = CNT_W'(ALERT_CYC_P - 1);
    localparam logic [CNT_W-1:0] SHIP_LIM  = CNT_W'(SHIP_HOLD_CYC_P - 1);
    localparam logic [CNT_W-1:0] RST_LIM   = CNT_W'(RESET_HOLD_CYC_P - 1);
    localparam logic [CNT_W-1:0] OFF_LIM   = CNT_W'(SWITCH_OFF_CYC_P - 1);
    localparam int               SYNC_W    = 5 + LIM_W;
    // Idle levels: enable pin high, button high, thermistor in window, so no false edge
    localparam logic [SYNC_W-1:0] SYNC_RST = {6'h00, 5'h0E};

    function automatic logic [LIM_W-1:0] min_lim(input logic [LIM_W-1:0] a,
                                                 input logic [LIM_W-1:0] b);
        min_lim = (a < b) ? a : b;
    endfunction

    logic [SYNC_W-1:0]  sync_s1_r;
    logic [SYNC_W-1:0]  sync_s2_r;
    logic               boost_s;
    logic               ce_n_s;
    logic               btn_s;
    logic               therm_s;
    logic               supply_s;
    logic [LIM_W-1:0]   limit_pin_s;
    logic [2:0]         ctrl_r;
    logic [LIM_W-1:0]   inlim_r;
    logic [IRQ_W-1:0]   irq_stat_r;
    logic [IRQ_W-1:0]   irq_en_r;
    logic [IRQ_W-1:0]   irq_clr;
    logic [IRQ_W-1:0]   ev;
    logic               therm_prev_r;
    logic               boost_r;
    logic               charge_r;
    logic [LIM_W-1:0]   lim_r;
    logic               alert_oe_r;
    logic               alert_out_r;
    logic [CNT_W-1:0]   alert_cnt_r;
    logic               irq_r;
    logic [DATA_W-1:0]  rdata_r;
    switch_state_e      sw_state_r;
    logic               switch_on_r;
    logic [CNT_W-1:0]   hold_cnt_r;
    logic               hold_fired_r;
    logic [CNT_W-1:0]   off_cnt_r;
    logic               hold_fire;
    logic               ship_cmd;
    logic               switch_ev;
    logic               charge_nxt;
    logic               boost_nxt;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; button stage resets high so an idle pad reads high
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_s1_r <= SYNC_RST;
            sync_s2_r <= SYNC_RST;
        end else begin
            sync_s1_r <= {input_limit_pin, input_supply_ok, thermistor_sense_ok,
                          push_button_input, charge_enable_n_pin, boost_request_pin};
            sync_s2_r <= sync_s1_r;
        end
    end

    assign boost_s     = sync_s2_r[0];
    assign ce_n_s      = sync_s2_r[1];
    assign btn_s       = sync_s2_r[2];
    assign therm_s     = sync_s2_r[3];
    assign supply_s    = sync_s2_r[4];
    assign limit_pin_s = sync_s2_r[SYNC_W-1:5];

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register writes
    assign irq_clr  = (wr && addr == REG_IRQ_CLR) ? wdata[IRQ_W-1:0] : '0;
    assign ship_cmd = wr && addr == REG_SHIP && wdata[SHIP_ENTER_BIT];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_r   <= CTRL_RST;
            inlim_r  <= INLIM_RST;
            irq_en_r <= IRQ_EN_RST;
        end else if (wr) begin
            if (addr == REG_CTRL) begin
                ctrl_r <= wdata[2:0];
            end
            if (addr == REG_INLIM) begin
                inlim_r <= wdata[LIM_W-1:0];
            end
            if (addr == REG_IRQ_EN) begin
                irq_en_r <= wdata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Boost, charge and input limit
    assign boost_nxt  = ctrl_r[CTRL_BOOST_BIT] && boost_s;
    assign charge_nxt = ctrl_r[CTRL_CHARGE_BIT] && !ce_n_s && therm_s;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            boost_r  <= 1'b0;
            charge_r <= 1'b0;
            lim_r    <= INLIM_RST;
        end else begin
            boost_r  <= boost_nxt;
            charge_r <= charge_nxt;
            if (ctrl_r[CTRL_PINLIM_BIT]) begin
                lim_r <= min_lim(limit_pin_s, inlim_r);
            end else begin
                lim_r <= inlim_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Push-button hold timer and battery switch control
    always_comb begin
        hold_fire = 1'b0;
        if (!btn_s && !hold_fired_r) begin
            if (sw_state_r == SW_SHIP && hold_cnt_r >= SHIP_LIM) begin
                hold_fire = 1'b1;
            end else if (sw_state_r == SW_ON && !supply_s && hold_cnt_r >= RST_LIM) begin
                hold_fire = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hold_cnt_r   <= '0;
            hold_fired_r <= 1'b0;
        end else if (btn_s) begin
            hold_cnt_r   <= '0;
            hold_fired_r <= 1'b0;
        end else if (hold_fire) begin
            hold_fired_r <= 1'b1;
        end else if (!hold_fired_r && hold_cnt_r != '1) begin
            hold_cnt_r <= hold_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sw_state_r <= SW_ON;
            off_cnt_r  <= '0;
        end else begin
            unique case (sw_state_r)
                SW_ON: begin
                    off_cnt_r <= '0;
                    if (hold_fire) begin
                        sw_state_r <= SW_OFF;
                    end else if (ship_cmd) begin
                        sw_state_r <= SW_SHIP;
                    end
                end
                SW_SHIP: begin
                    if (hold_fire) begin
                        sw_state_r <= SW_ON;
                    end
                end
                SW_OFF: begin
                    if (off_cnt_r == OFF_LIM) begin
                        sw_state_r <= SW_ON;
                    end else begin
                        off_cnt_r <= off_cnt_r + 1'b1;
                    end
                end
                default: begin
                    sw_state_r <= SW_ON;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            switch_on_r <= 1'b1;
        end else begin
            switch_on_r <= (sw_state_r == SW_ON);
        end
    end

    assign switch_ev = (sw_state_r == SW_SHIP && hold_fire) ||
                       (sw_state_r == SW_OFF && off_cnt_r == OFF_LIM);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Events, sticky status and interrupt
    always_ff @(posedge core_clk) begin
        if (rst) begin
            therm_prev_r <= 1'b1;
        end else begin
            therm_prev_r <= therm_s;
        end
    end

    assign ev[EV_CHARGE] = charge_nxt != charge_r;
    assign ev[EV_BOOST]  = boost_nxt != boost_r;
    assign ev[EV_THERM]  = therm_prev_r && !therm_s;
    assign ev[EV_SWITCH] = switch_ev;

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
            irq_r      <= |(((irq_stat_r & ~irq_clr) | ev) & irq_en_r);
        end
    end

    // Alert pulse; events during a pulse do not stretch it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alert_oe_r  <= 1'b0;
            alert_out_r <= 1'b0;
            alert_cnt_r <= '0;
        end else if (alert_oe_r) begin
            if (alert_cnt_r == ALERT_LIM) begin
                alert_oe_r <= 1'b0;
            end else begin
                alert_cnt_r <= alert_cnt_r + 1'b1;
            end
        end else if (|ev) begin
            alert_oe_r  <= 1'b1;
            alert_cnt_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (rd) begin
            unique case (addr)
                REG_CTRL:     rdata_r <= {5'h00, ctrl_r};
                REG_INLIM:    rdata_r <= {2'h0, inlim_r};
                REG_STATUS:   rdata_r <= {2'h0, supply_s, sw_state_r == SW_SHIP, switch_on_r,
                                          therm_s, charge_r, boost_r};
                REG_IRQ_STAT: rdata_r <= {4'h0, irq_stat_r};
                REG_IRQ_EN:   rdata_r <= {4'h0, irq_en_r};
                REG_EFF_LIM:  rdata_r <= {2'h0, lim_r};
                default:      rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata             = rdata_r;
    assign alert_out         = alert_out_r;
    assign alert_oe          = alert_oe_r;
    assign boost_enable      = boost_r;
    assign charge_enable     = charge_r;
    assign battery_switch_on = switch_on_r;
    assign input_limit_eff   = lim_r;
    assign irq               = irq_r;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [CNT_W-1:0] chk_alert_len_r;
    always_ff @(posedge core_clk) begin
        if (rst || !alert_oe_r) begin
            chk_alert_len_r <= '0;
        end else begin
            chk_alert_len_r <= chk_alert_len_r + 1'b1;
        end
    end

    a_alert_not_long: assert property (alert_oe_r |-> chk_alert_len_r <= ALERT_LIM)
        else $error("alert pulse too long");
    a_alert_full_len: assert property ($fell(alert_oe_r) |->
        $past(chk_alert_len_r) == ALERT_LIM && !alert_out_r)
        else $error("alert pulse too short");
    a_boost_gated: assert property (boost_r |->
        $past(ctrl_r[CTRL_BOOST_BIT]) && $past(boost_s))
        else $error("boost without config and pin");
    a_charge_gated: assert property (charge_r |->
        $past(ctrl_r[CTRL_CHARGE_BIT]) && !$past(ce_n_s))
        else $error("charge without config and pin");
    a_limit_min: assert property (ctrl_r[CTRL_PINLIM_BIT] ##1 1 |->
        lim_r <= $past(inlim_r) && lim_r <= $past(limit_pin_s))
        else $error("effective limit above a source");
    a_limit_reg_only: assert property (!ctrl_r[CTRL_PINLIM_BIT] |=>
        lim_r == $past(inlim_r))
        else $error("pin limit used while disabled");
    a_therm_suspend: assert property (!therm_s |=> !charge_r)
        else $error("charging while thermistor out of window");
    a_ship_exit: assert property (sw_state_r == SW_SHIP && !btn_s && !hold_fired_r &&
        hold_cnt_r == SHIP_LIM |=> sw_state_r == SW_ON ##1 battery_switch_on)
        else $error("ship mode not left after hold");
    a_reset_off: assert property ($rose(sw_state_r == SW_OFF) |=>
        !battery_switch_on[*8])
        else $error("switch not held off during reset");
    a_off_len: assert property (sw_state_r == SW_OFF && off_cnt_r == OFF_LIM |=>
        sw_state_r == SW_ON)
        else $error("switch off time wrong");
    a_idle_high: assert property ($fell(rst) |-> btn_s)
        else $error("button does not idle high");
    a_hold_restart: assert property (btn_s |=> hold_cnt_r == '0 && !hold_fired_r)
        else $error("hold timer not restarted");
    a_irq_level: assert property (irq_r == |(irq_stat_r & $past(irq_en_r)))
        else $error("interrupt level does not follow enabled status");

    c_alert_pulse: cover property ($fell(alert_oe_r));
    c_ship_exit:   cover property (sw_state_r == SW_SHIP ##1 sw_state_r == SW_ON);
    c_sys_reset:   cover property (sw_state_r == SW_OFF ##1 sw_state_r == SW_ON);
    c_charge_on:   cover property ($rose(charge_r));

endmodule

// ### verif/charger_pads_model.sv
// Board-side model of the charger pins: pull-ups and system-driven levels
`timescale 1ns/1ps

module charger_pads_model (
    input  wire logic alert_out,  // Alert pad level from the block
    input  wire logic alert_oe,   // Alert pad drive enable
    input  wire logic press,      // User holds the button
    input  wire logic ce_low,     // System asks for charging
    output logic      alert_pad,  // Host view of the alert line
    output logic      button_pin, // Button pin level
    output logic      ce_n_pin    // Charge enable pin level
);
    // External pull-up returns the released alert line high
    assign alert_pad  = alert_oe ? alert_out : 1'b1;
    // Internal pull-up keeps an untouched button high
    assign button_pin = press ? 1'b0 : 1'b1;
    // Enable pin is always driven, never left floating
    assign ce_n_pin   = ~ce_low;
endmodule

// ### verif/charger_pin_control_logic_tb.sv
// Self-checking bench for the charger pin control block
`timescale 1ns/1ps

module charger_pin_control_logic_tb;
    import charger_pkg::*;
    localparam int ALERT_N = 8;
    localparam int HOLD_N  = 20;
    localparam int OFF_N   = 10;
    logic              core_clk  = 1'b0;
    logic              rst       = 1'b1;
    logic [ADDR_W-1:0] addr      = '0;
    logic [DATA_W-1:0] wdata     = '0;
    logic              wr        = 1'b0;
    logic              rd        = 1'b0;
    logic              boost_pin = 1'b0;
    logic              ce_low    = 1'b0;
    logic              press     = 1'b0;
    logic              therm_ok  = 1'b1;
    logic              supply_ok = 1'b1;
    logic [LIM_W-1:0]  lim_pin   = 6'h20;
    logic [DATA_W-1:0] rdata;
    logic              alert_out, alert_oe, alert_pad, button_pin, ce_n_pin;
    logic              boost_en, charge_en, sw_on, irq;
    logic [LIM_W-1:0]  lim_eff, lim_x;
    logic [LIM_W-1:0]  tp [3] = '{6'h20, 6'h0C, 6'h0C};
    logic [LIM_W-1:0]  tf [3] = '{6'h10, 6'h30, 6'h30};
    logic [2:0]        te     = 3'b011;
    int                error_cnt = 0;
    int                cmp_count = 0;
    int                n;

    charger_pin_ctrl #(.ALERT_CYC_P(ALERT_N), .SHIP_HOLD_CYC_P(HOLD_N),
        .RESET_HOLD_CYC_P(HOLD_N), .SWITCH_OFF_CYC_P(OFF_N)) dut (
        .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .boost_request_pin(boost_pin), .charge_enable_n_pin(ce_n_pin),
        .push_button_input(button_pin), .thermistor_sense_ok(therm_ok),
        .input_supply_ok(supply_ok), .input_limit_pin(lim_pin), .alert_out(alert_out),
        .alert_oe(alert_oe), .boost_enable(boost_en), .charge_enable(charge_en),
        .battery_switch_on(sw_on), .input_limit_eff(lim_eff), .irq(irq));

    charger_pads_model pads (.alert_out(alert_out), .alert_oe(alert_oe), .press(press),
        .ce_low(ce_low), .alert_pad(alert_pad), .button_pin(button_pin),
        .ce_n_pin(ce_n_pin));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp_v);
        cmp_count++;
        if (seen !== exp_v) begin
            error_cnt++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp_v);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        check(rdata, e);
    endtask

    // Waits for the selected line to go low, then counts its low cycles
    task automatic low_len(input logic sel, output int len);
        int k;
        k   = 0;
        len = 0;
        while ((sel ? sw_on : alert_pad) !== 1'b0) begin
            tick(1);
            k++;
            if (k > 60) begin
                error_cnt++;
                finish_test();
            end
        end
        while ((sel ? sw_on : alert_pad) === 1'b0 && len < 200) begin
            tick(1);
            len++;
        end
    endtask

    task automatic press_for(input int k);
        @(posedge core_clk);
        press <= 1'b1;
        repeat (k) @(posedge core_clk);
        press <= 1'b0;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        tick(2);
        check(8'(sw_on), 8'h01);
        check(8'(irq), 8'h00);
        check(8'(lim_eff), 8'h3F);
        rd_reg(REG_CTRL, 8'h02);
        rd_reg(REG_INLIM, 8'h3F);
        rd_reg(REG_IRQ_EN, 8'h00);
        rd_reg(REG_STATUS, 8'h2C);
        rd_reg(REG_IRQ_CLR, 8'h00);
        rd_reg(8'h08, 8'h00);
        wr_reg(REG_EFF_LIM, 8'h11);
        rd_reg(REG_EFF_LIM, 8'h3F);
        // Every combination of boost and charge config bits and their pins
        for (int i = 0; i < 16; i++) begin
            wr_reg(REG_CTRL, {6'h00, i[1:0]});
            @(posedge core_clk);
            boost_pin <= i[2];
            ce_low    <= ~i[3];
            tick(6);
            check(8'(boost_en), 8'(i[0] & i[2]));
            check(8'(charge_en), 8'(i[1] & ~i[3]));
        end
        @(posedge core_clk);
        ce_low <= 1'b1;
        tick(6);
        wr_reg(REG_IRQ_CLR, 8'h0F);
        @(posedge core_clk);
        therm_ok <= 1'b0;
        tick(6);
        check(8'(charge_en), 8'h00);
        rd_reg(REG_IRQ_STAT, 8'h05);
        @(posedge core_clk);
        therm_ok <= 1'b1;
        tick(6);
        check(8'(charge_en), 8'h01);
        // Effective limit is the lower of pin and register codes, or the register code when pin limit is off
        for (int j = 0; j < 3; j++) begin
            wr_reg(REG_INLIM, {2'b00, tf[j]});
            wr_reg(REG_CTRL, {5'h00, te[j], 2'b11});
            @(posedge core_clk);
            lim_pin <= tp[j];
            tick(6);
            lim_x = te[j] ? ((tp[j] < tf[j]) ? tp[j] : tf[j]) : tf[j];
            check(8'(lim_eff), 8'(lim_x));
            rd_reg(REG_EFF_LIM, {2'b00, lim_x});
        end
        // Boost drop raises one alert pulse and a maskable interrupt
        tick(20);
        wr_reg(REG_IRQ_CLR, 8'h0F);
        wr_reg(REG_CTRL, 8'h02);
        low_len(1'b0, n);
        check(8'(n), 8'(ALERT_N));
        rd_reg(REG_IRQ_STAT, 8'h02);
        wr_reg(REG_IRQ_EN, 8'h01);
        tick(2);
        check(8'(irq), 8'h00);
        wr_reg(REG_IRQ_EN, 8'h02);
        tick(2);
        check(8'(irq), 8'h01);
        wr_reg(REG_IRQ_CLR, 8'h02);
        tick(2);
        check(8'(irq), 8'h00);
        rd_reg(REG_IRQ_STAT, 8'h00);
        // Ship mode: short press ignored, long press exits
        wr_reg(REG_SHIP, 8'h01);
        tick(3);
        check(8'(sw_on), 8'h00);
        rd_reg(REG_STATUS, 8'h36);
        press_for(HOLD_N / 2);
        check(8'(sw_on), 8'h00);
        press_for(HOLD_N + 6);
        check(8'(sw_on), 8'h01);
        rd_reg(REG_IRQ_STAT, 8'h08);
        // No supply: long press cycles the switch once
        @(posedge core_clk);
        supply_ok <= 1'b0;
        @(posedge core_clk);
        press <= 1'b1;
        low_len(1'b1, n);
        check(8'(n), 8'(OFF_N));
        tick(HOLD_N + 5);
        check(8'(sw_on), 8'h01);
        @(posedge core_clk);
        press <= 1'b0;
        tick(4);
        finish_test();
    end
endmodule
